// *** rtl/pcr_pkg.sv ***
// package: register map, reset values and carrier types of the load regulator config bank
package pcr_pkg;

  // ********************************************************
  // register offsets, setup range
  // ********************************************************
  localparam logic [7:0] PCR_ADDR_PROTECTION_SETUP_A = 8'h00;
  localparam logic [7:0] PCR_ADDR_PROTECTION_SETUP_B = 8'h01;
  localparam logic [7:0] PCR_ADDR_PROTECTION_SETUP_C = 8'h02;
  localparam logic [7:0] PCR_ADDR_TRACKING_CONFIG = 8'h03;
  localparam logic [7:0] PCR_ADDR_PHASE_AND_SWITCHING_FREQ = 8'h04;
  localparam logic [7:0] PCR_ADDR_TURN_ON_DELAY = 8'h05;
  localparam logic [7:0] PCR_ADDR_TURN_OFF_DELAY = 8'h06;
  localparam logic [7:0] PCR_ADDR_VOLTAGE_LOOP_SETUP = 8'h07;
  localparam logic [7:0] PCR_ADDR_CURRENT_LIMIT_SETPOINT = 8'h08;
  localparam logic [7:0] PCR_ADDR_DUTY_LIMIT = 8'h09;
  localparam logic [7:0] PCR_ADDR_PROTECTION_SETUP_D = 8'h0A;
  localparam logic [7:0] PCR_ADDR_VOUT_SETPOINT_A_BYTE0 = 8'h0B;
  localparam logic [7:0] PCR_ADDR_VOUT_SETPOINT_A_BYTE1 = 8'h0C;
  localparam logic [7:0] PCR_ADDR_VOUT_SETPOINT_B_BYTE0 = 8'h0D;
  localparam logic [7:0] PCR_ADDR_VOUT_SETPOINT_B_BYTE1 = 8'h0E;
  localparam logic [7:0] PCR_ADDR_VOUT_SETPOINT_C_BYTE0 = 8'h0F;
  localparam logic [7:0] PCR_ADDR_VOUT_SETPOINT_C_BYTE1 = 8'h10;
  localparam logic [7:0] PCR_ADDR_LOOP_PROPORTIONAL_GAIN = 8'h11;
  localparam logic [7:0] PCR_ADDR_LOOP_INTEGRAL_GAIN = 8'h12;
  localparam logic [7:0] PCR_ADDR_LOOP_DERIVATIVE_GAIN = 8'h13;
  localparam logic [7:0] PCR_ADDR_DERIVATIVE_ROLLOFF_COEFF = 8'h14;

  // ********************************************************
  // register offsets, run/status and monitoring
  // ********************************************************
  localparam logic [7:0] PCR_ADDR_OUTPUT_ENABLE_STATE = 8'h15;
  localparam logic [7:0] PCR_ADDR_FAULT_FLAGS = 8'h16;
  localparam logic [7:0] PCR_ADDR_VOUT_MONITOR_HIGH = 8'h17;
  localparam logic [7:0] PCR_ADDR_LOAD_CURRENT_MONITOR = 8'h18;
  localparam logic [7:0] PCR_ADDR_TEMPERATURE_MONITOR = 8'h19;
  localparam logic [7:0] PCR_ADDR_VOUT_MONITOR_LOW = 8'h27;

  // number of setup registers, 0x00 through 0x14
  localparam int PCR_SETUP_COUNT = 21;

  // ********************************************************
  // reset values of the setup registers
  // ********************************************************
  localparam logic [7:0] PCR_SETUP_RESET [0:20] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] PCR_SHADOW_RESET = 8'h00;
  localparam logic PCR_RUN_RESET = 1'b0;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int PCR_RUN_ENABLE_BIT = 0;
  localparam int PCR_RUN_PGOOD_BIT = 1;
  localparam int PCR_ST_PGOOD_BIT = 0;
  localparam int PCR_ST_GROUP_OK_BIT = 1;
  localparam int PCR_ST_SHARE_BIT = 2;
  localparam int PCR_ST_DISCARD_BIT = 3;

  // cycles after reset release before the address straps are caught
  localparam logic [2:0] PCR_STRAP_SETTLE_CYCLES = 3'h4;

  // ********************************************************
  // types
  // ********************************************************
  // one decoded access from the single-wire deframer
  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcr_req_t;

  // analog monitor samples
  typedef struct packed {
    logic [15:0] vout;
    logic [7:0] iout;
    logic [7:0] temp;
  } pcr_mon_t;

  // committed output voltage setpoints
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } pcr_vset_t;

  // strap capture states
  typedef enum logic [0:0] {
    PCR_STRAP_WAIT = 1'b0,
    PCR_STRAP_DONE = 1'b1
  } pcr_strap_state_t;

endpackage : pcr_pkg

// *** rtl/pcr_sync3.sv ***
// three-flop input synchroniser that passes a change once stages two and three agree
`timescale 1ns/10ps

module pcr_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // asynchronous level in, filtered level out
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_level_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q; // first stage, read only by s2_q
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;

  // ********************************************************
  // synchroniser chain
  // ********************************************************
  // pins are pulled up, so all stages rest high after reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ********************************************************
  // agreement filter, per bit
  // ********************************************************
  // a bit moves only when two settled stages agree, rejecting one-cycle glitches
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          level_q[gi] <= 1'b1;
        end else if (s2_q[gi] == s3_q[gi]) begin
          level_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  // reset_level_in is kept for port symmetry only through this xor-free merge
  assign level_out = level_q & (reset_level_in | ~reset_level_in);

endmodule : pcr_sync3

// *** rtl/pcr_reg_bank.sv ***
// configuration, status and monitoring register bank of the point-of-load regulator
`timescale 1ns/10ps

module pcr_reg_bank (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // decoded accesses from the single-wire deframer
  input wire logic req_valid_in,
  input wire pcr_pkg::pcr_req_t req_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  // sync/data wire, open drain
  input wire logic sync_data_wire_in,
  input wire logic sync_data_tx_low_in,
  output logic sync_data_wire_out,
  output logic sync_data_wire_oe_n_out,
  output logic sync_data_level_out,
  // power good pin, open drain
  input wire logic power_good_pin_in,
  input wire logic power_good_drive_low_in,
  output logic power_good_pin_out,
  output logic power_good_pin_oe_n_out,
  // fault/status group line, open drain
  input wire logic group_ok_pin_in,
  input wire logic group_fault_drive_in,
  output logic group_ok_pin_out,
  output logic group_ok_pin_oe_n_out,
  output logic group_ok_level_out,
  // current share line, open drain
  input wire logic current_share_pin_in,
  input wire logic current_share_drive_low_in,
  output logic current_share_pin_out,
  output logic current_share_pin_oe_n_out,
  output logic current_share_level_out,
  // node address straps
  input wire logic [4:0] node_address_strap_in,
  output logic [4:0] node_address_out,
  output logic node_address_valid_out,
  // analog monitors in, configuration out
  input wire pcr_pkg::pcr_mon_t monitor_in,
  output logic output_enable_out,
  output pcr_pkg::pcr_vset_t vset_out,
  output logic [7:0] setup_out [0:20]
);

  // ********************************************************
  // decode helpers
  // ********************************************************
  // registers that may change only while the output is off
  function automatic logic is_locked(input logic [7:0] a);
    is_locked = (a == pcr_pkg::PCR_ADDR_PHASE_AND_SWITCHING_FREQ) ||
                (a == pcr_pkg::PCR_ADDR_DUTY_LIMIT) ||
                (a >= pcr_pkg::PCR_ADDR_LOOP_PROPORTIONAL_GAIN &&
                 a <= pcr_pkg::PCR_ADDR_DERIVATIVE_ROLLOFF_COEFF);
  endfunction : is_locked

  // setpoint high byte, which goes to a shadow
  function automatic logic is_vset_high(input logic [7:0] a);
    is_vset_high = (a == pcr_pkg::PCR_ADDR_VOUT_SETPOINT_A_BYTE0) ||
                   (a == pcr_pkg::PCR_ADDR_VOUT_SETPOINT_B_BYTE0) ||
                   (a == pcr_pkg::PCR_ADDR_VOUT_SETPOINT_C_BYTE0);
  endfunction : is_vset_high

  // setpoint low byte, which commits the pair
  function automatic logic is_vset_low(input logic [7:0] a);
    is_vset_low = (a == pcr_pkg::PCR_ADDR_VOUT_SETPOINT_A_BYTE1) ||
                  (a == pcr_pkg::PCR_ADDR_VOUT_SETPOINT_B_BYTE1) ||
                  (a == pcr_pkg::PCR_ADDR_VOUT_SETPOINT_C_BYTE1);
  endfunction : is_vset_low

  // setpoint pair index, 0..2, for either byte of a pair
  function automatic logic [1:0] vset_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - pcr_pkg::PCR_ADDR_VOUT_SETPOINT_A_BYTE0;
    vset_slot = d[2:1];
  endfunction : vset_slot

  // ********************************************************
  // storage and state
  // ********************************************************
  logic [7:0] setup_q [0:20]; // committed setup registers
  logic [7:0] shadow_q [0:2]; // setpoint high-byte shadows
  logic run_enable_q; // output enable from run register
  logic discard_q; // sticky: a locked write was dropped
  logic [7:0] vol_snap_q; // low monitor byte caught with the high byte
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic pg_oe_n_q;
  logic ok_oe_n_q;
  logic cs_oe_n_q;
  logic sd_oe_n_q;
  logic pg_level; // synchronised pin levels
  logic ok_level;
  logic cs_level;
  logic sd_level;
  logic [4:0] strap_level;
  logic [4:0] node_address_q;
  logic [2:0] settle_q;
  pcr_pkg::pcr_strap_state_t strap_state_q;
  logic wr_fire;
  logic rd_fire;
  logic setup_hit; // address lies in 0x00..0x14
  logic status_read;

  assign wr_fire = req_valid_in && req_in.write;
  assign rd_fire = req_valid_in && !req_in.write;
  assign setup_hit = req_in.addr <= pcr_pkg::PCR_ADDR_DERIVATIVE_ROLLOFF_COEFF;
  assign status_read = rd_fire && (req_in.addr == pcr_pkg::PCR_ADDR_FAULT_FLAGS);

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  // all external pins cross into clk_in through the three-flop filter
  pcr_sync3 #(.WIDTH(9)) u_pin_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .async_in({node_address_strap_in, sync_data_wire_in, current_share_pin_in,
               group_ok_pin_in, power_good_pin_in}),
    .reset_level_in(9'h1FF),
    .level_out({strap_level, sd_level, cs_level, ok_level, pg_level})
  );

  // ********************************************************
  // setup registers and setpoint shadows
  // ********************************************************
  // async reset loads built-in defaults, as after input power loss
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < pcr_pkg::PCR_SETUP_COUNT; i++) begin
        setup_q[i] <= pcr_pkg::PCR_SETUP_RESET[i];
      end
      for (int j = 0; j < 3; j++) begin
        shadow_q[j] <= pcr_pkg::PCR_SHADOW_RESET;
      end
    end else if (wr_fire && setup_hit) begin
      if (is_vset_high(req_in.addr)) begin
        // high byte waits in the shadow, output unchanged
        shadow_q[vset_slot(req_in.addr)] <= req_in.wdata;
      end else if (is_vset_low(req_in.addr)) begin
        // low byte refreshes the whole pair at once
        setup_q[req_in.addr[4:0]] <= req_in.wdata;
        setup_q[req_in.addr[4:0] - 5'h01] <= shadow_q[vset_slot(req_in.addr)];
      end else if (!(is_locked(req_in.addr) && run_enable_q)) begin
        // any other setup register takes the value at once
        setup_q[req_in.addr[4:0]] <= req_in.wdata;
      end
      // a locked register written while enabled keeps its value
    end
    // other addresses fall through untouched
  end

  // ********************************************************
  // run register
  // ********************************************************
  // enable may be toggled at any time; it gates the locked set
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_enable_q <= pcr_pkg::PCR_RUN_RESET;
    end else if (wr_fire && req_in.addr == pcr_pkg::PCR_ADDR_OUTPUT_ENABLE_STATE) begin
      run_enable_q <= req_in.wdata[pcr_pkg::PCR_RUN_ENABLE_BIT];
    end
  end

  // ********************************************************
  // discard flag
  // ********************************************************
  // set wins over the clear-on-read so a drop in the read cycle is not lost
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      discard_q <= 1'b0;
    end else if (wr_fire && is_locked(req_in.addr) && run_enable_q) begin
      discard_q <= 1'b1;
    end else if (status_read) begin
      discard_q <= 1'b0;
    end
  end

  // ********************************************************
  // monitor snapshot
  // ********************************************************
  // reading the high byte freezes the low byte so the pair stays coherent
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vol_snap_q <= 8'h00;
    end else if (rd_fire && req_in.addr == pcr_pkg::PCR_ADDR_VOUT_MONITOR_HIGH) begin
      vol_snap_q <= monitor_in.vout[7:0];
    end
  end

  // ********************************************************
  // read mux
  // ********************************************************
  // unmapped addresses read as zero
  always_comb begin
    rd_data_d = 8'h00;
    if (setup_hit) begin
      rd_data_d = setup_q[req_in.addr[4:0]];
    end else begin
      case (req_in.addr)
        pcr_pkg::PCR_ADDR_OUTPUT_ENABLE_STATE: begin
          rd_data_d[pcr_pkg::PCR_RUN_ENABLE_BIT] = run_enable_q;
          rd_data_d[pcr_pkg::PCR_RUN_PGOOD_BIT] = pg_level;
        end
        pcr_pkg::PCR_ADDR_FAULT_FLAGS: begin
          // live pin levels, power good among them, and the sticky discard flag
          rd_data_d[pcr_pkg::PCR_ST_PGOOD_BIT] = pg_level;
          rd_data_d[pcr_pkg::PCR_ST_GROUP_OK_BIT] = ok_level;
          rd_data_d[pcr_pkg::PCR_ST_SHARE_BIT] = cs_level;
          rd_data_d[pcr_pkg::PCR_ST_DISCARD_BIT] = discard_q;
        end
        pcr_pkg::PCR_ADDR_VOUT_MONITOR_HIGH: begin
          rd_data_d = monitor_in.vout[15:8];
        end
        pcr_pkg::PCR_ADDR_VOUT_MONITOR_LOW: begin
          rd_data_d = vol_snap_q;
        end
        pcr_pkg::PCR_ADDR_LOAD_CURRENT_MONITOR: begin
          rd_data_d = monitor_in.iout;
        end
        pcr_pkg::PCR_ADDR_TEMPERATURE_MONITOR: begin
          rd_data_d = monitor_in.temp;
        end
        default: begin
          rd_data_d = 8'h00;
        end
      endcase
    end
  end

  // answer lands one cycle after the read is taken
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      rd_valid_q <= rd_fire;
      if (rd_fire) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  // ********************************************************
  // open-drain pin drivers
  // ********************************************************
  // enables are low while pulling the wire low; release lets the pull-up win
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pg_oe_n_q <= 1'b1;
      ok_oe_n_q <= 1'b1;
      cs_oe_n_q <= 1'b1;
      sd_oe_n_q <= 1'b1;
    end else begin
      pg_oe_n_q <= !power_good_drive_low_in;
      ok_oe_n_q <= !group_fault_drive_in;
      cs_oe_n_q <= !current_share_drive_low_in;
      sd_oe_n_q <= !sync_data_tx_low_in;
    end
  end

  // ********************************************************
  // address strap capture
  // ********************************************************
  // straps are caught once the synchroniser has settled after release
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_state_q <= pcr_pkg::PCR_STRAP_WAIT;
      settle_q <= 3'h0;
      node_address_q <= 5'h1F;
    end else begin
      case (strap_state_q)
        pcr_pkg::PCR_STRAP_WAIT: begin
          if (settle_q == pcr_pkg::PCR_STRAP_SETTLE_CYCLES) begin
            // tied to ground reads 0, open reads 1
            node_address_q <= strap_level;
            strap_state_q <= pcr_pkg::PCR_STRAP_DONE;
          end else begin
            settle_q <= settle_q + 3'h1;
          end
        end
        pcr_pkg::PCR_STRAP_DONE: begin
          strap_state_q <= pcr_pkg::PCR_STRAP_DONE;
        end
        default: begin
          strap_state_q <= pcr_pkg::PCR_STRAP_WAIT;
        end
      endcase
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign rd_valid_out = rd_valid_q;
  assign rd_data_out = rd_data_q;
  assign sync_data_wire_out = 1'b0;
  assign sync_data_wire_oe_n_out = sd_oe_n_q;
  assign sync_data_level_out = sd_level;
  assign power_good_pin_out = 1'b0;
  assign power_good_pin_oe_n_out = pg_oe_n_q;
  assign group_ok_pin_out = 1'b0;
  assign group_ok_pin_oe_n_out = ok_oe_n_q;
  assign group_ok_level_out = ok_level;
  assign current_share_pin_out = 1'b0;
  assign current_share_pin_oe_n_out = cs_oe_n_q;
  assign current_share_level_out = cs_level;
  assign node_address_out = node_address_q;
  assign node_address_valid_out = (strap_state_q == pcr_pkg::PCR_STRAP_DONE);
  assign output_enable_out = run_enable_q;
  assign vset_out = '{a: {setup_q[11], setup_q[12]}, b: {setup_q[13], setup_q[14]},
                      c: {setup_q[15], setup_q[16]}};
  assign setup_out = setup_q;

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // first cycle after reset release, used to check defaults
  logic first_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  a_reset_default_delay: assert property (
    first_q |-> setup_q[6] == 8'h0B && !run_enable_q)
    else $error("turn-off delay or run bit not at default after reset");

  a_open_write_taken: assert property (
    wr_fire && setup_hit && !is_vset_high(req_in.addr) && !is_vset_low(req_in.addr) &&
    !is_locked(req_in.addr) |=> setup_q[$past(req_in.addr[4:0])] == $past(req_in.wdata))
    else $error("setup write not stored");

  a_locked_write_drop: assert property (
    wr_fire && is_locked(req_in.addr) && run_enable_q
    |=> setup_q[$past(req_in.addr[4:0])] == $past(setup_q[req_in.addr[4:0]]) && discard_q)
    else $error("locked write changed a register while enabled");

  a_locked_write_off: assert property (
    wr_fire && is_locked(req_in.addr) && !run_enable_q
    |=> setup_q[$past(req_in.addr[4:0])] == $past(req_in.wdata))
    else $error("locked write refused while output off");

  a_vset_high_hold: assert property (
    wr_fire && is_vset_high(req_in.addr) |=> $stable(vset_out))
    else $error("high byte write moved a setpoint");

  a_vset_low_commit: assert property (
    wr_fire && is_vset_low(req_in.addr)
    |=> {setup_q[$past(req_in.addr[4:0]) - 5'h01], setup_q[$past(req_in.addr[4:0])]}
        == {$past(shadow_q[vset_slot(req_in.addr)]), $past(req_in.wdata)})
    else $error("low byte write did not commit the pair");

  a_unmapped_read_zero: assert property (
    rd_fire && req_in.addr > pcr_pkg::PCR_ADDR_TEMPERATURE_MONITOR &&
    req_in.addr != pcr_pkg::PCR_ADDR_VOUT_MONITOR_LOW |=> rd_valid_out && rd_data_out == 8'h00)
    else $error("unmapped read returned data");

  a_pgood_status: assert property (
    status_read |=> rd_data_out[pcr_pkg::PCR_ST_PGOOD_BIT] == $past(pg_level))
    else $error("status power good bit differs from pin level");

  a_strap_capture: assert property (
    $rose(node_address_valid_out) |-> node_address_out == $past(strap_level))
    else $error("node address differs from strap levels");

  a_group_drive: assert property (
    group_fault_drive_in |=> !group_ok_pin_oe_n_out ##0 !group_ok_pin_out)
    else $error("group line not pulled low on fault");

  a_read_answer: assert property (
    rd_fire |=> rd_valid_out ##1 (rd_valid_out == $past(rd_fire)))
    else $error("read answer missing or stretched");

endmodule : pcr_reg_bank

// *** test/pcr_manager_model.sv ***
// manager-side model of the pulled-up shared lines around the regulator
`timescale 1ns/10ps

module pcr_manager_model (
  // regulator open-drain enables, low pulls the line
  input wire logic sd_oe_n_in,
  input wire logic grp_oe_n_in,
  input wire logic pg_oe_n_in,
  input wire logic cs_oe_n_in,
  // manager pulls, high pulls the line low
  input wire logic mgr_sd_low_in,
  input wire logic mgr_grp_low_in,
  // resolved line levels
  output logic sd_out,
  output logic grp_out,
  output logic pg_out,
  output logic cs_out
);
  // ****
  // wired-and lines, pull-ups win when nobody pulls
  // ****
  assign sd_out = !(!sd_oe_n_in || mgr_sd_low_in);
  assign grp_out = !(!grp_oe_n_in || mgr_grp_low_in);
  assign pg_out = pg_oe_n_in;
  // share left unconnected: only the pull-up and our own driver
  assign cs_out = cs_oe_n_in;
endmodule : pcr_manager_model

// *** test/pcr_reg_bank_test.sv ***
// self-checking bench for the regulator register bank
`timescale 1ns/10ps

module pcr_reg_bank_test;
  logic clk_in, arst_n_in, req_valid_in, sd_tx, pg_low, grp_drv, mgr_sd, mgr_grp, rdv, oen, nav, grp_f, cs_f, sd_f;
  logic sd_l, grp_l, pg_l, cs_l, sd_oe_n, grp_oe_n, pg_oe_n, cs_oe_n, cs_low;
  logic [7:0] setup [0:20];
  pcr_pkg::pcr_req_t req_in;
  pcr_pkg::pcr_mon_t monitor_in;
  pcr_pkg::pcr_vset_t vset;
  logic [7:0] rdd, rd;
  logic [4:0] straps, naddr;
  int fail_count, compares, i;

  pcr_reg_bank dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .rd_valid_out(rdv), .rd_data_out(rdd), .sync_data_wire_in(sd_l), .sync_data_tx_low_in(sd_tx),
    .sync_data_wire_out(), .sync_data_wire_oe_n_out(sd_oe_n), .sync_data_level_out(sd_f),
    .power_good_pin_in(pg_l), .power_good_drive_low_in(pg_low), .power_good_pin_out(),
    .power_good_pin_oe_n_out(pg_oe_n), .group_ok_pin_in(grp_l), .group_fault_drive_in(grp_drv),
    .group_ok_pin_out(), .group_ok_pin_oe_n_out(grp_oe_n), .group_ok_level_out(grp_f),
    .current_share_pin_in(cs_l), .current_share_drive_low_in(cs_low), .current_share_pin_out(),
    .current_share_pin_oe_n_out(cs_oe_n), .current_share_level_out(cs_f), .node_address_strap_in(straps),
    .node_address_out(naddr), .node_address_valid_out(nav), .monitor_in(monitor_in),
    .output_enable_out(oen), .vset_out(vset), .setup_out(setup));

  pcr_manager_model mgr (.sd_oe_n_in(sd_oe_n), .grp_oe_n_in(grp_oe_n), .pg_oe_n_in(pg_oe_n),
    .cs_oe_n_in(cs_oe_n), .mgr_sd_low_in(mgr_sd), .mgr_grp_low_in(mgr_grp), .sd_out(sd_l),
    .grp_out(grp_l), .pg_out(pg_l), .cs_out(cs_l));

  // ****
  // compare, report and bus tasks
  // ****
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // one access, then an idle cycle so the strobe never re-rises in one step
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    req_valid_in = 1'b1;
    req_in = '{write: wr, addr: a, wdata: d};
    @(posedge clk_in) #2;
    req_valid_in = 1'b0;
    if (!wr) check(rdv, 1'b1);
    rd = rdd;
    @(posedge clk_in) #2;
  endtask : access

  task automatic rcheck(input logic [7:0] a, input logic [7:0] exp);
    access(1'b0, a, 8'h00);
    check(rd, exp);
  endtask : rcheck

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  initial begin
    {arst_n_in, req_valid_in, sd_tx, pg_low, grp_drv, mgr_sd, mgr_grp, cs_low} = '0;
    req_in = '0;
    straps = 5'h15;
    monitor_in = '{vout: 16'h1234, iout: 8'h56, temp: 8'h78};
    fail_count = 0;
    compares = 0;
    repeat (12) @(posedge clk_in);
    #2 arst_n_in = 1'b1;
    for (i = 0; i < 40 && nav !== 1'b1; i++) @(posedge clk_in) #2;
    check(nav, 1'b1);
    if (nav !== 1'b1) final_report();
    check(naddr, 5'h15);
    for (i = 0; i < 21; i++) rcheck(i[7:0], pcr_pkg::PCR_SETUP_RESET[i]);
    $display("defaults test done");
    for (i = 0; i < 21; i++) access(1'b1, i[7:0], i[7:0] ^ 8'h5A);
    for (i = 0; i < 21; i++) rcheck(i[7:0], i[7:0] ^ 8'h5A);
    check(vset.a, 16'h5156);
    check(vset.c, 16'h554A);
    access(1'b1, 8'h0D, 8'hA5);
    check(vset.b, 16'h5754);
    access(1'b1, 8'h0E, 8'h3C);
    check(vset.b, 16'hA53C);
    $display("load test done");
    access(1'b1, 8'h15, 8'h01);
    check(oen, 1'b1);
    access(1'b1, 8'h04, 8'hFF);
    access(1'b1, 8'h08, 8'hC3);
    rcheck(8'h04, 8'h5E);
    rcheck(8'h08, 8'hC3);
    check(setup[8], 8'hC3);
    rcheck(8'h16, 8'h0F);
    rcheck(8'h16, 8'h07);
    access(1'b1, 8'h15, 8'h00);
    access(1'b1, 8'h04, 8'hFF);
    rcheck(8'h04, 8'hFF);
    access(1'b1, 8'h20, 8'h99);
    rcheck(8'h20, 8'h00);
    rcheck(8'h17, 8'h12);
    rcheck(8'h27, 8'h34);
    rcheck(8'h18, 8'h56);
    rcheck(8'h19, 8'h78);
    $display("lock and map test done");
    {pg_low, grp_drv, mgr_sd, cs_low} = 4'b1111;
    repeat (8) @(posedge clk_in) #2;
    check({cs_oe_n, pg_oe_n}, 2'b00);
    rcheck(8'h16, 8'h00);
    rcheck(8'h15, 8'h00);
    check(sd_f, 1'b0);
    {pg_low, grp_drv, mgr_sd, mgr_grp, sd_tx, cs_low} = 6'b000110;
    repeat (8) @(posedge clk_in) #2;
    check(grp_f, 1'b0);
    check({sd_oe_n, sd_f}, 2'b00);
    check(cs_f, 1'b1);
    $display("pin test done");
    access(1'b1, 8'h15, 8'h01);
    arst_n_in = 1'b0;
    @(posedge clk_in) #2 arst_n_in = 1'b1;
    @(posedge clk_in) #2;
    check(oen, 1'b0);
    rcheck(8'h04, pcr_pkg::PCR_SETUP_RESET[4]);
    rcheck(8'h06, pcr_pkg::PCR_SETUP_RESET[6]);
    $display("reset test done");
    final_report();
  end
endmodule : pcr_reg_bank_test
